// ===== periph_sysctl_defines.vh
// Purpose: Offsets, field positions, reset values and codes for the
//          peripheral clock, reset and access control block.
// Assumes: AXI4-Lite byte addresses, 32-bit data, one register per word.
// Notes:   Definitions only; included by bare name.
`ifndef PERIPH_SYSCTL_DEFINES_VH
`define PERIPH_SYSCTL_DEFINES_VH

// Register byte offsets
`define OFF_CLOCK_GATE   8'h00
`define OFF_SOFT_RESET   8'h04
`define OFF_GATE_LOCK    8'h08
`define OFF_RESET_CAUSE  8'h0C
`define OFF_RESET_TRIG   8'h10
`define OFF_ACCESS_CPU   8'h14
`define OFF_ACCESS_COP   8'h18
`define OFF_ACCESS_DMA   8'h1C

// Reset values
`define RST_CLOCK_GATE   32'h0000_0000
`define RST_SOFT_RESET   32'h0000_0000
`define RST_ACCESS       32'h0000_0000

// Lock register fields
`define LOCK_GATE_BIT    0
`define LOCK_SRST_BIT    1
`define LOCK_ACC_BIT     2

// Reset cause bit positions
`define CAUSE_POR        0
`define CAUSE_EXT        1
`define CAUSE_WDOG       2
`define CAUSE_SW         3

// Software system reset trigger key
`define SYS_RESET_KEY    32'h0000_A5A5

// Access qualifier codes
`define ACC_RW           2'h3
`define ACC_RO           2'h1

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== access_filter.v
// Purpose: Decodes per-master two-bit qualifiers into per-peripheral
//          read and write permissions, registered.
// Assumes: Qualifier word holds two bits per peripheral, peripheral 0 lowest.
// Notes:   Registered so the outputs start from flip-flops.
`include "periph_sysctl_defines.vh"

module access_filter #(
  parameter NP = 8
) (
  // Clock and reset
  input  wire            clk,
  input  wire            rst_n,
  // Qualifiers, two bits per peripheral
  input  wire [2*NP-1:0] qual,
  // Decoded permissions
  output reg  [NP-1:0]   rd_ok_r,
  output reg  [NP-1:0]   wr_ok_r
);

  integer i;
  reg [NP-1:0] rd_nxt;
  reg [NP-1:0] wr_nxt;

  // Only the read-write code passes writes; read-only passes reads, others block all
  always @* begin
    rd_nxt = {NP{1'b0}};
    wr_nxt = {NP{1'b0}};
    for (i = 0; i < NP; i = i + 1) begin
      wr_nxt[i] = (qual[2*i +: 2] == `ACC_RW);
      rd_nxt[i] = (qual[2*i +: 2] == `ACC_RW) || (qual[2*i +: 2] == `ACC_RO);
    end
  end

  // Permissions registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ok_r <= {NP{1'b0}};
      wr_ok_r <= {NP{1'b0}};
    end else begin
      rd_ok_r <= rd_nxt;
      wr_ok_r <= wr_nxt;
    end
  end

endmodule

// ===== periph_clock_reset_access_ctrl.v
// Purpose: Per-peripheral clock gating, soft reset, gating lock, reset
//          cause capture and per-master access filtering.
// Assumes: Single clock; AXI4-Lite register slave; request inputs synchronous.
// Notes:   Lock bits clear only on device reset. Access filter is registered.
`include "periph_sysctl_defines.vh"

// Overview of operation
// - Each peripheral clock gated off after reset
// - Lock freezes clock gating configuration
// - Locked registers writable again only after reset
// - Soft resets held while set, cleared on reset
// - Status register latches most recent reset cause
// - Software system reset triggerable internally and recorded
// - Per master, per peripheral access decision
// - Two-bit qualifier per master selects access
module periph_clock_reset_access_ctrl #(
  parameter NP = 8
) (
  // Clock and resets
  input  wire            clk,
  input  wire            rst_n,
  input  wire            power_on_reset_n,
  // Reset event sources outside this block
  input  wire            ext_reset_seen,
  input  wire            wdog_reset_seen,
  // AXI4-Lite write address
  input  wire [7:0]      s_awaddr,
  input  wire            s_awvalid,
  output reg             s_awready,
  // AXI4-Lite write data
  input  wire [31:0]     s_wdata,
  input  wire [3:0]      s_wstrb,
  input  wire            s_wvalid,
  output reg             s_wready,
  // AXI4-Lite write response
  output reg  [1:0]      s_bresp,
  output reg             s_bvalid,
  input  wire            s_bready,
  // AXI4-Lite read
  input  wire [7:0]      s_araddr,
  input  wire            s_arvalid,
  output reg             s_arready,
  output reg  [31:0]     s_rdata,
  output reg  [1:0]      s_rresp,
  output reg             s_rvalid,
  input  wire            s_rready,
  // Peripheral controls
  output reg  [NP-1:0]   periph_clk_en_r,
  output reg  [NP-1:0]   periph_reset_r,
  output reg             sys_reset_req_r,
  // Master access requests, one bit per peripheral
  input  wire [NP-1:0]   cpu_rd_req,
  input  wire [NP-1:0]   cpu_wr_req,
  input  wire [NP-1:0]   cop_rd_req,
  input  wire [NP-1:0]   cop_wr_req,
  input  wire [NP-1:0]   dma_rd_req,
  input  wire [NP-1:0]   dma_wr_req,
  // Granted accesses toward peripherals
  output reg  [NP-1:0]   cpu_rd_gnt_r,
  output reg  [NP-1:0]   cpu_wr_gnt_r,
  output reg  [NP-1:0]   cop_rd_gnt_r,
  output reg  [NP-1:0]   cop_wr_gnt_r,
  output reg  [NP-1:0]   dma_rd_gnt_r,
  output reg  [NP-1:0]   dma_wr_gnt_r
);

  // Control registers
  reg [NP-1:0]   peripheral_clock_gate_ctrl_r;
  reg [NP-1:0]   peripheral_soft_reset_ctrl_r;
  reg [2:0]      lock_r;
  reg [3:0]      reset_cause_status_r;
  reg [2*NP-1:0] acc_cpu_r;
  reg [2*NP-1:0] acc_cop_r;
  reg [2*NP-1:0] acc_dma_r;
  // Write channel capture
  reg            aw_held_r;
  reg            w_held_r;
  reg [7:0]      awaddr_r;
  reg [31:0]     wdata_r;
  reg [3:0]      wstrb_r;

  wire [NP-1:0] cpu_rd_ok;
  wire [NP-1:0] cpu_wr_ok;
  wire [NP-1:0] cop_rd_ok;
  wire [NP-1:0] cop_wr_ok;
  wire [NP-1:0] dma_rd_ok;
  wire [NP-1:0] dma_wr_ok;

  // Byte-lane merge used by the gate, soft reset and access registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (st[b]) merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // Address known to the map
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFF_CLOCK_GATE) || (a == `OFF_SOFT_RESET) ||
               (a == `OFF_GATE_LOCK) || (a == `OFF_RESET_CAUSE) ||
               (a == `OFF_RESET_TRIG) || (a == `OFF_ACCESS_CPU) ||
               (a == `OFF_ACCESS_COP) || (a == `OFF_ACCESS_DMA);
    end
  endfunction

  wire do_wr = aw_held_r && w_held_r && !s_bvalid;

  // Byte-merged candidates; each register keeps only its own low bits
  wire [31:0] gate_mrg = merge({{(32-NP){1'b0}}, peripheral_clock_gate_ctrl_r},
                               wdata_r, wstrb_r);
  wire [31:0] srst_mrg = merge({{(32-NP){1'b0}}, peripheral_soft_reset_ctrl_r},
                               wdata_r, wstrb_r);
  wire [31:0] cpu_mrg  = merge({{(32-2*NP){1'b0}}, acc_cpu_r}, wdata_r, wstrb_r);
  wire [31:0] cop_mrg  = merge({{(32-2*NP){1'b0}}, acc_cop_r}, wdata_r, wstrb_r);
  wire [31:0] dma_mrg  = merge({{(32-2*NP){1'b0}}, acc_dma_r}, wdata_r, wstrb_r);

  // Address and data taken in either order, held until response issued
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `RESP_OKAY;
    end else begin
      s_awready <= !aw_held_r && !s_awready && !s_bvalid;
      s_wready  <= !w_held_r && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_wdata;
        wstrb_r  <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; lock bits are sticky until device reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_clock_gate_ctrl_r <= {NP{1'b0}};
      peripheral_soft_reset_ctrl_r <= {NP{1'b0}};
      lock_r                       <= 3'h0;
      acc_cpu_r                    <= {2*NP{1'b0}};
      acc_cop_r                    <= {2*NP{1'b0}};
      acc_dma_r                    <= {2*NP{1'b0}};
      sys_reset_req_r              <= 1'b0;
    end else begin
      sys_reset_req_r <= 1'b0;
      if (do_wr) begin
        if (awaddr_r == `OFF_CLOCK_GATE) begin
          if (!lock_r[`LOCK_GATE_BIT])
            peripheral_clock_gate_ctrl_r <= gate_mrg[NP-1:0];
        end else if (awaddr_r == `OFF_SOFT_RESET) begin
          if (!lock_r[`LOCK_SRST_BIT])
            peripheral_soft_reset_ctrl_r <= srst_mrg[NP-1:0];
        end else if (awaddr_r == `OFF_GATE_LOCK) begin
          lock_r <= lock_r | (wstrb_r[0] ? wdata_r[2:0] : 3'h0);
        end else if (awaddr_r == `OFF_RESET_TRIG) begin
          sys_reset_req_r <= (wdata_r == `SYS_RESET_KEY);
        end else if (awaddr_r == `OFF_ACCESS_CPU) begin
          if (!lock_r[`LOCK_ACC_BIT])
            acc_cpu_r <= cpu_mrg[2*NP-1:0];
        end else if (awaddr_r == `OFF_ACCESS_COP) begin
          if (!lock_r[`LOCK_ACC_BIT])
            acc_cop_r <= cop_mrg[2*NP-1:0];
        end else if (awaddr_r == `OFF_ACCESS_DMA) begin
          if (!lock_r[`LOCK_ACC_BIT])
            acc_dma_r <= dma_mrg[2*NP-1:0];
        end
      end
    end
  end

  // Cause register lives on power-on reset only so a warm reset keeps it.
  // Each new reset event replaces the old cause; a read-only register.
  always @(posedge clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      reset_cause_status_r <= 4'h1;
    end else if (ext_reset_seen) begin
      reset_cause_status_r <= 4'h2;
    end else if (wdog_reset_seen) begin
      reset_cause_status_r <= 4'h4;
    end else if (sys_reset_req_r) begin
      reset_cause_status_r <= 4'h8;
    end
  end

  // Read channel, one outstanding read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= `RESP_OKAY;
    end else begin
      s_arready <= !s_arready && !s_rvalid;
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rresp   <= mapped(s_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        if (s_araddr == `OFF_CLOCK_GATE)
          s_rdata <= {{(32-NP){1'b0}}, peripheral_clock_gate_ctrl_r};
        else if (s_araddr == `OFF_SOFT_RESET)
          s_rdata <= {{(32-NP){1'b0}}, peripheral_soft_reset_ctrl_r};
        else if (s_araddr == `OFF_GATE_LOCK)
          s_rdata <= {29'h0000_0000, lock_r};
        else if (s_araddr == `OFF_RESET_CAUSE)
          s_rdata <= {28'h000_0000, reset_cause_status_r};
        else if (s_araddr == `OFF_ACCESS_CPU)
          s_rdata <= {{(32-2*NP){1'b0}}, acc_cpu_r};
        else if (s_araddr == `OFF_ACCESS_COP)
          s_rdata <= {{(32-2*NP){1'b0}}, acc_cop_r};
        else if (s_araddr == `OFF_ACCESS_DMA)
          s_rdata <= {{(32-2*NP){1'b0}}, acc_dma_r};
        else
          s_rdata <= 32'h0000_0000;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Clock enables and soft resets driven from flip-flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_clk_en_r <= {NP{1'b0}};
      periph_reset_r  <= {NP{1'b0}};
    end else begin
      periph_clk_en_r <= peripheral_clock_gate_ctrl_r;
      periph_reset_r  <= peripheral_soft_reset_ctrl_r;
    end
  end

  // One qualifier decoder per master
  access_filter #(.NP(NP)) u_acc_cpu (
    .clk(clk), .rst_n(rst_n), .qual(acc_cpu_r), .rd_ok_r(cpu_rd_ok), .wr_ok_r(cpu_wr_ok));
  access_filter #(.NP(NP)) u_acc_cop (
    .clk(clk), .rst_n(rst_n), .qual(acc_cop_r), .rd_ok_r(cop_rd_ok), .wr_ok_r(cop_wr_ok));
  access_filter #(.NP(NP)) u_acc_dma (
    .clk(clk), .rst_n(rst_n), .qual(acc_dma_r), .rd_ok_r(dma_rd_ok), .wr_ok_r(dma_wr_ok));

  // Blocked requests never reach the peripheral, so it stays unchanged
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rd_gnt_r <= {NP{1'b0}};
      cpu_wr_gnt_r <= {NP{1'b0}};
      cop_rd_gnt_r <= {NP{1'b0}};
      cop_wr_gnt_r <= {NP{1'b0}};
      dma_rd_gnt_r <= {NP{1'b0}};
      dma_wr_gnt_r <= {NP{1'b0}};
    end else begin
      cpu_rd_gnt_r <= cpu_rd_req & cpu_rd_ok;
      cpu_wr_gnt_r <= cpu_wr_req & cpu_wr_ok;
      cop_rd_gnt_r <= cop_rd_req & cop_rd_ok;
      cop_wr_gnt_r <= cop_wr_req & cop_wr_ok;
      dma_rd_gnt_r <= dma_rd_req & dma_rd_ok;
      dma_wr_gnt_r <= dma_wr_req & dma_wr_ok;
    end
  end

endmodule

// ===== master_model.sv
// Purpose: Stand-in for the CPU, coprocessor and DMA request side
// Assumes: Requests are levels, changed just after a rising edge
// Notes:   All three masters repeat one commanded mask, so grants differ only by qualifier
module master_model (
  // Clock
  input  logic       clk,
  // Commanded request masks
  input  logic [7:0] rd_mask,
  input  logic [7:0] wr_mask,
  // Requests toward the filter
  output logic [7:0] cpu_rd_req = '0,
  output logic [7:0] cpu_wr_req = '0,
  output logic [7:0] cop_rd_req = '0,
  output logic [7:0] cop_wr_req = '0,
  output logic [7:0] dma_rd_req = '0,
  output logic [7:0] dma_wr_req = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Requests follow the command one edge later, like a registered master
  always @(posedge clk) begin
    cpu_rd_req <= rd_mask;
    cpu_wr_req <= wr_mask;
    cop_rd_req <= rd_mask;
    cop_wr_req <= wr_mask;
    dma_rd_req <= rd_mask;
    dma_wr_req <= wr_mask;
  end
endmodule

// ===== periph_ctrl_properties.sv
// Purpose: Port-level checks for the clock, reset and access control block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Grants lag requests by one edge, so requests are seen through $past
module periph_ctrl_checker #(
  parameter NP = 8
) (
  // Clock and reset
  input logic          clk,
  input logic          rst_n,
  // Requests and grants
  input logic [NP-1:0] cpu_rd_req,
  input logic [NP-1:0] cpu_wr_req,
  input logic [NP-1:0] cop_rd_req,
  input logic [NP-1:0] cop_wr_req,
  input logic [NP-1:0] dma_rd_req,
  input logic [NP-1:0] dma_wr_req,
  input logic [NP-1:0] cpu_rd_gnt_r,
  input logic [NP-1:0] cpu_wr_gnt_r,
  input logic [NP-1:0] cop_rd_gnt_r,
  input logic [NP-1:0] cop_wr_gnt_r,
  input logic [NP-1:0] dma_rd_gnt_r,
  input logic [NP-1:0] dma_wr_gnt_r,
  // Other outputs
  input logic          sys_reset_req_r,
  input logic          s_rvalid,
  input logic [1:0]    s_rresp,
  input logic [31:0]   s_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A grant never appears without a request one edge earlier
  AST_CPU_RD: assert property ((cpu_rd_gnt_r & ~$past(cpu_rd_req)) == '0)
    else $error("cpu read grant without request");
  AST_CPU_WR: assert property ((cpu_wr_gnt_r & ~$past(cpu_wr_req)) == '0)
    else $error("cpu write grant without request");
  AST_COP: assert property (({cop_rd_gnt_r, cop_wr_gnt_r}
    & ~$past({cop_rd_req, cop_wr_req})) == '0)
    else $error("coprocessor grant without request");
  AST_DMA: assert property (({dma_rd_gnt_r, dma_wr_gnt_r}
    & ~$past({dma_rd_req, dma_wr_req})) == '0)
    else $error("dma grant without request");
  // Write permission only comes with read permission
  AST_CPU_WR_RD: assert property ((cpu_wr_gnt_r & $past(cpu_rd_req) & ~cpu_rd_gnt_r) == '0)
    else $error("cpu write allowed while read blocked");
  AST_DMA_WR_RD: assert property ((dma_wr_gnt_r & $past(dma_rd_req) & ~dma_rd_gnt_r) == '0)
    else $error("dma write allowed while read blocked");
  // Software system reset is a single pulse
  AST_SYS_PULSE: assert property ($rose(sys_reset_req_r) |=> !sys_reset_req_r [*2])
    else $error("system reset request longer than one cycle");
  // Refused reads return zero data
  AST_SLVERR_ZERO: assert property (s_rvalid && s_rresp == 2'h2 |-> s_rdata == 32'h0)
    else $error("error read returned data");
endmodule

bind periph_clock_reset_access_ctrl periph_ctrl_checker #(.NP(NP)) periph_ctrl_checker_i (
  .clk, .rst_n, .cpu_rd_req, .cpu_wr_req, .cop_rd_req, .cop_wr_req, .dma_rd_req,
  .dma_wr_req, .cpu_rd_gnt_r, .cpu_wr_gnt_r, .cop_rd_gnt_r, .cop_wr_gnt_r,
  .dma_rd_gnt_r, .dma_wr_gnt_r, .sys_reset_req_r, .s_rvalid, .s_rresp, .s_rdata
);

// ===== tb_top.sv
// Purpose: Self-checking bench for the clock, reset and access control block
// Assumes: AXI4-Lite master tasks, 250 MHz clock, requests from master_model
// Notes:   Lock clears only on rst_n, so it is tested before the cause checks and a mid-run reset
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench signals, named after the ports they drive or watch
  logic        clk = 1'h0, rst_n = 1'h0, power_on_reset_n = 1'h0;
  logic        ext_reset_seen = 1'h0, wdog_reset_seen = 1'h0;
  logic [7:0]  s_awaddr = '0, s_araddr = '0, rd_mask = '0, wr_mask = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic        s_arvalid = 1'h0, s_rready = 1'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sys_reset_req_r;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  periph_clk_en_r, periph_reset_r, cpu_rd_req, cpu_wr_req, cop_rd_req;
  logic [7:0]  cop_wr_req, dma_rd_req, dma_wr_req, cpu_rd_gnt_r, cpu_wr_gnt_r;
  logic [7:0]  cop_rd_gnt_r, cop_wr_gnt_r, dma_rd_gnt_r, dma_wr_gnt_r;
  int          num_errors = 0, comparisons = 0, cycles = 0, pulses = 0;

  periph_clock_reset_access_ctrl #(.NP(8)) periph_clock_reset_access_ctrl_i (
    .clk, .rst_n, .power_on_reset_n, .ext_reset_seen, .wdog_reset_seen,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .periph_clk_en_r, .periph_reset_r, .sys_reset_req_r,
    .cpu_rd_req, .cpu_wr_req, .cop_rd_req, .cop_wr_req, .dma_rd_req, .dma_wr_req,
    .cpu_rd_gnt_r, .cpu_wr_gnt_r, .cop_rd_gnt_r, .cop_wr_gnt_r, .dma_rd_gnt_r,
    .dma_wr_gnt_r
  );
  master_model master_model_i (
    .clk, .rd_mask, .wr_mask, .cpu_rd_req, .cpu_wr_req, .cop_rd_req, .cop_wr_req,
    .dma_rd_req, .dma_wr_req
  );

  // 4 ns period
  always #2 clk = ~clk;

  // Hang ceiling, well above the run length; also counts reset request pulses
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sys_reset_req_r === 1'h1) pulses <= pulses + 1;
    if (cycles == 3000) begin
      $display("wrong value at %0t: run did not finish in time", $time);
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input [31:0] got, input [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let n edges pass, then step off the edge so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'h1;
    s_wvalid  <= 1'h1;
    s_bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready === 1'h1) s_awvalid <= 1'h0;
      if (s_wready === 1'h1) s_wvalid <= 1'h0;
    end while (s_bvalid !== 1'h1);
    s_bready <= 1'h0;
    chk(s_bresp, er);
  endtask

  task automatic rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'h1;
    s_rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready === 1'h1) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1);
    s_rready <= 1'h0;
    chk(s_rdata, exp);
    chk(s_rresp, er);
  endtask

  // One-cycle reset event, then read back the recorded cause
  task automatic cause(input logic e, input logic w, input [31:0] exp);
    @(posedge clk);
    ext_reset_seen  <= e;
    wdog_reset_seen <= w;
    @(posedge clk);
    ext_reset_seen  <= 1'h0;
    wdog_reset_seen <= 1'h0;
    rd(8'h0C, exp, 2'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n            <= 1'h1;
    power_on_reset_n <= 1'h1;
    tick(1);
    chk(periph_clk_en_r, 32'h0);
    chk(periph_reset_r, 32'h0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h0C, 32'h1, 2'h0);
    wr(8'h00, 32'hA5, 2'h0);
    wr(8'h04, 32'h3C, 2'h0);
    tick(2);
    chk(periph_clk_en_r, 32'hA5);
    chk(periph_reset_r, 32'h3C);
    // Codes 3,1,0,2 on peripherals 0..3, code 3 above
    for (int m = 0; m < 3; m++) wr(8'h14 + 8'(m * 4), 32'hFF87, 2'h0);
    rd_mask <= 8'hFF;
    wr_mask <= 8'hFF;
    tick(3);
    chk({cpu_rd_gnt_r, cop_rd_gnt_r, dma_rd_gnt_r}, 32'hF3F3F3);
    chk({cpu_wr_gnt_r, cop_wr_gnt_r, dma_wr_gnt_r}, 32'hF1F1F1);
    // No byte lane enabled, so the gate register must keep its value
    s_wstrb <= 4'h0;
    wr(8'h00, 32'hFF, 2'h0);
    s_wstrb <= 4'hF;
    rd(8'h00, 32'hA5, 2'h0);
    wr(8'h08, 32'h7, 2'h0);
    wr(8'h00, 32'hFF, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    tick(3);
    chk(periph_clk_en_r, 32'hA5);
    chk(periph_reset_r, 32'h3C);
    chk(cpu_wr_gnt_r, 32'hF1);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 32'h7, 2'h0);
    rd(8'h00, 32'hA5, 2'h0);
    cause(1'h1, 1'h0, 32'h2);
    cause(1'h0, 1'h1, 32'h4);
    cause(1'h1, 1'h1, 32'h2);
    wr(8'h10, 32'h5A5A, 2'h0);
    tick(1);
    chk(pulses, 0);
    wr(8'h10, 32'hA5A5, 2'h0);
    tick(2);
    chk(pulses, 1);
    rd(8'h0C, 32'h8, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h24, 32'h1, 2'h2);
    // Mid-run device reset clears lock and controls but keeps the cause
    @(posedge clk);
    rst_n <= 1'h0;
    tick(2);
    chk(periph_clk_en_r, 32'h0);
    @(posedge clk);
    rst_n <= 1'h1;
    tick(1);
    rd(8'h0C, 32'h8, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h00, 32'h5A, 2'h0);
    tick(3);
    chk(periph_clk_en_r, 32'h5A);
    chk(cpu_rd_gnt_r, 32'h0);
    @(posedge clk);
    power_on_reset_n <= 1'h0;
    @(posedge clk);
    power_on_reset_n <= 1'h1;
    rd(8'h0C, 32'h1, 2'h0);
    chk(periph_clk_en_r, 32'h5A);
    tally_and_finish();
  end
endmodule
